/* File: logic/pvsf_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] Scale and frequency reach hardware at once when idle, else after restore or supply cycle.
// [R2] Loop scale word sets the internal feedback divider.
// [R3] Loop scale is linear: exponent 15:11, mantissa 10:0, exponent resets 11001b.
// [R4] Divider picks 0.125, 0.25, 0.5 or 1.0 from decoded scale.
// [R5] Any in-range scale word is stored and read back unchanged.
// [R6] Reference scaling uses the stored scale word, not the divider factor.
// [R7] Out-of-range writes are refused, flag status and notify host.
// [R8] Output floor word is 16-bit unsigned; target never goes below it.
// [R9] Target below floor during conversion warns and clamps to floor.
// [R10] Warning sets none-of-above, vout and min/max status, notifies host.
// [R11] Reprogramming the floor above the target gives the same response.
// [R12] Floor word obeys the same valid bounds as the ceiling limit.
// [R13] Frequency word is linear khz and sets the channel frequency.
// [R14] Frequency exponent is generated at reset from the stored frequency.
// [R15] Decoded frequency maps to one of twelve effective frequency buckets.
// [R16] Host avoids frequencies above 1100 khz without external rail supply.
// [R17] Conversion starts when sensed input reaches the turn-on threshold.
// [R18] Linear words decode as signed mantissa times two to signed exponent.
module pvsf_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] rd_data_r,
  output logic rd_ack_r,
  // converter side
  input wire logic conv_en,
  input wire logic nvm_restore,
  input wire logic analog_input_supply_cycle,
  input wire pvsf_pkg::pvsf_nvm_t nvm,
  input wire logic [15:0] target_req,
  input wire logic [15:0] vin_sense,
  input wire pvsf_pkg::pvsf_stat_t stat_clr,
  // hardware settings and status
  output logic [1:0] div_sel_r,
  output logic [15:0] loop_hw_r,
  output logic [10:0] fsw_eff_r,
  output logic [15:0] target_r,
  output logic conv_start_r,
  output pvsf_pkg::pvsf_stat_t stat_r,
  output logic notify_r
);
  // ==========================================
  // decode helpers
  function automatic logic signed [47:0] lin_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0] e;
    m = {{37{w[pvsf_pkg::MAN_HI]}}, w[pvsf_pkg::MAN_HI:0]};
    e = w[pvsf_pkg::EXP_HI:pvsf_pkg::EXP_LO] + pvsf_pkg::FRAC_BIAS;
    lin_fix = m <<< e; // R18
  endfunction : lin_fix

  function automatic logic [1:0] div_of(input logic [15:0] w);
    logic signed [47:0] v;
    v = lin_fix(w);
    if (v <= pvsf_pkg::Q_EIGHTH) div_of = pvsf_pkg::DIV_EIGHTH; // R4
    else if (v <= pvsf_pkg::Q_QUARTER) div_of = pvsf_pkg::DIV_QUARTER;
    else if (v <= pvsf_pkg::Q_HALF) div_of = pvsf_pkg::DIV_HALF;
    else div_of = pvsf_pkg::DIV_ONE;
  endfunction : div_of

  function automatic logic [10:0] fsw_map(input logic [15:0] w);
    logic signed [47:0] v;
    v = lin_fix(w);
    fsw_map = pvsf_pkg::FSW_EFF[pvsf_pkg::FSW_N-1];
    // scan downward so the lowest matching bucket wins
    for (int i = pvsf_pkg::FSW_N - 1; i >= 0; i--) begin
      if (v < $signed({21'h0, pvsf_pkg::FSW_UB[i], 16'h0})) fsw_map = pvsf_pkg::FSW_EFF[i]; // R15
    end
  endfunction : fsw_map

  function automatic logic valid_of(input logic [7:0] c, input logic [15:0] w);
    logic signed [47:0] v;
    v = lin_fix(w);
    case (c)
      pvsf_pkg::CMD_LOOP_SCALE: valid_of = (v > pvsf_pkg::Q_ZERO) && (v <= pvsf_pkg::Q_ONE);
      pvsf_pkg::CMD_VOUT_FLOOR: valid_of = (w >= pvsf_pkg::VOUT_LIM_LO) &&
                                           (w <= pvsf_pkg::VOUT_LIM_HI); // R12
      pvsf_pkg::CMD_FSW: valid_of = (v > pvsf_pkg::Q_ZERO) &&
                         (v < $signed({21'h0, pvsf_pkg::FSW_UB[pvsf_pkg::FSW_N-1], 16'h0}));
      pvsf_pkg::CMD_INPUT_TURN_ON_THRESHOLD: valid_of = (v >= pvsf_pkg::INPUT_TURN_ON_THRESHOLD_LO) && (v <= pvsf_pkg::INPUT_TURN_ON_THRESHOLD_HI);
      default: valid_of = 1'b0;
    endcase
  endfunction : valid_of

  // ==========================================
  // stored command words
  logic load_r, load_nxt;
  logic [15:0] loop_r, loop_nxt;
  logic [15:0] floor_r, floor_nxt;
  logic [15:0] fsw_r, fsw_nxt;
  logic [15:0] input_turn_on_threshold_r, input_turn_on_threshold_nxt;
  logic wr_bad;
  logic [15:0] fsw_boot;

  always_comb begin
    // exponent picked so the nvm khz figure fits an 11-bit signed mantissa
    if (nvm.fsw_khz[10:0] >= pvsf_pkg::FREQUENCY_MANTISSA_LIM || nvm.fsw_khz[15:11] != 5'h0) begin
      fsw_boot = {5'h01, nvm.fsw_khz[11:1]}; // R14
    end else begin
      fsw_boot = {5'h00, nvm.fsw_khz[10:0]}; // R14
    end
  end

  always_comb begin
    load_nxt = 1'b0;
    loop_nxt = loop_r;
    floor_nxt = floor_r;
    fsw_nxt = fsw_r;
    input_turn_on_threshold_nxt = input_turn_on_threshold_r;
    wr_bad = 1'b0;
    if (load_r || nvm_restore) begin
      loop_nxt = {pvsf_pkg::LOOP_EXP_RST, nvm.loop_man}; // R3
      floor_nxt = nvm.vout_floor;
      fsw_nxt = fsw_boot;
      input_turn_on_threshold_nxt = nvm.input_turn_on_threshold;
    end else if (cmd_wr) begin
      if (!valid_of(cmd_code, cmd_wdata)) begin
        wr_bad = 1'b1; // R7
      end else begin
        case (cmd_code)
          pvsf_pkg::CMD_LOOP_SCALE: loop_nxt = cmd_wdata; // R5
          pvsf_pkg::CMD_VOUT_FLOOR: floor_nxt = cmd_wdata; // R8
          pvsf_pkg::CMD_FSW: fsw_nxt = cmd_wdata; // R13
          pvsf_pkg::CMD_INPUT_TURN_ON_THRESHOLD: input_turn_on_threshold_nxt = cmd_wdata; // R17
          default: wr_bad = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      // nvm contents are taken one cycle after release, not under reset
      load_r <= 1'b1;
      loop_r <= {pvsf_pkg::LOOP_EXP_RST, 11'h0};
      floor_r <= 16'h0;
      fsw_r <= 16'h0;
      input_turn_on_threshold_r <= 16'h0;
    end else begin
      load_r <= load_nxt;
      loop_r <= loop_nxt;
      floor_r <= floor_nxt;
      fsw_r <= fsw_nxt;
      input_turn_on_threshold_r <= input_turn_on_threshold_nxt;
    end
  end

  // ==========================================
  // hardware copies
  logic hw_apply;
  logic apply_r, apply_nxt;
  logic [1:0] div_sel_nxt;
  logic [15:0] loop_hw_nxt;
  logic [10:0] fsw_eff_nxt;

  always_comb begin
    // reloaded words land one cycle before the plant takes them, else stale words apply
    apply_nxt = load_r || nvm_restore;
    // while converting, writes sit in the register but the plant keeps its setting
    hw_apply = !conv_en || analog_input_supply_cycle || apply_r; // R1
    div_sel_nxt = div_sel_r;
    loop_hw_nxt = loop_hw_r;
    fsw_eff_nxt = fsw_eff_r;
    if (hw_apply) begin
      div_sel_nxt = div_of(loop_r); // R2
      loop_hw_nxt = loop_r; // R6
      fsw_eff_nxt = fsw_map(fsw_r); // R13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      apply_r <= 1'b0;
      div_sel_r <= pvsf_pkg::DIV_ONE;
      loop_hw_r <= 16'h0;
      fsw_eff_r <= 11'h0;
    end else begin
      apply_r <= apply_nxt;
      div_sel_r <= div_sel_nxt;
      loop_hw_r <= loop_hw_nxt;
      fsw_eff_r <= fsw_eff_nxt;
    end
  end

  // ==========================================
  // floor clamp, status, start and readback
  logic below, below_r, below_nxt;
  logic [15:0] target_nxt;
  logic conv_start_nxt;
  pvsf_pkg::pvsf_stat_t stat_nxt;
  logic notify_nxt;
  logic [15:0] rd_data_nxt;

  always_comb begin
    below = conv_en && (target_req < floor_r); // R11
    below_nxt = below;
    target_nxt = (target_req < floor_r) ? floor_r : target_req; // R8
    if (below) target_nxt = floor_r; // R9
    conv_start_nxt = lin_fix(vin_sense) >= lin_fix(input_turn_on_threshold_r); // R17
    // a set in the clearing cycle survives
    stat_nxt = stat_r & ~stat_clr;
    notify_nxt = 1'b0;
    if (below && !below_r) begin
      stat_nxt.none_above = 1'b1; // R10
      stat_nxt.vout = 1'b1;
      stat_nxt.vout_minmax = 1'b1;
      notify_nxt = 1'b1; // R10
    end
    if (wr_bad) begin
      stat_nxt.cml_data = 1'b1; // R7
      notify_nxt = 1'b1;
    end
    case (cmd_code)
      pvsf_pkg::CMD_LOOP_SCALE: rd_data_nxt = loop_r; // R5
      pvsf_pkg::CMD_VOUT_FLOOR: rd_data_nxt = floor_r;
      pvsf_pkg::CMD_FSW: rd_data_nxt = fsw_r;
      pvsf_pkg::CMD_INPUT_TURN_ON_THRESHOLD: rd_data_nxt = input_turn_on_threshold_r;
      default: rd_data_nxt = 16'h0;
    endcase
    if (!cmd_rd) rd_data_nxt = rd_data_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      below_r <= 1'b0;
      target_r <= 16'h0;
      conv_start_r <= 1'b0;
      stat_r <= '0;
      notify_r <= 1'b0;
      rd_data_r <= 16'h0;
      rd_ack_r <= 1'b0;
    end else begin
      below_r <= below_nxt;
      target_r <= target_nxt;
      conv_start_r <= conv_start_nxt;
      stat_r <= stat_nxt;
      notify_r <= notify_nxt;
      rd_data_r <= rd_data_nxt;
      rd_ack_r <= cmd_rd;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_good_wr;
    cmd_wr && !load_r && !nvm_restore && valid_of(cmd_code, cmd_wdata);
  endsequence
  sequence s_same_rd;
    cmd_rd && $stable(cmd_code);
  endsequence
  // reload seen only once reset is gone, so reset values are never compared
  sequence s_reload;
    rst_b && (load_r || nvm_restore);
  endsequence

  AST_HW_BLOCKED: assert property (conv_en && !analog_input_supply_cycle && !apply_r
    |=> $stable(div_sel_r) && $stable(fsw_eff_r)) // R1
    else $error("hardware setting changed while converting");
  AST_RELOAD_APPLY: assert property (s_reload ##1 1'b1 |=> loop_hw_r == $past(loop_r)
    && fsw_eff_r == fsw_map($past(fsw_r))) // R1
    else $error("reloaded words not applied");
  AST_DIV_TRACK: assert property (rst_b && !conv_en ##1 !conv_en
    |-> div_sel_r == div_of($past(loop_r)))
    else $error("divider does not follow loop scale"); // R2
  AST_EXP_RESET: assert property ($rose(rst_b) |=> loop_r[15:11] == pvsf_pkg::LOOP_EXP_RST)
    else $error("loop scale exponent not at reset value"); // R3
  AST_READBACK: assert property (s_good_wr ##1 s_same_rd |=> rd_data_r == $past(cmd_wdata, 2))
    else $error("written word not read back"); // R5
  AST_RD_ACK: assert property (cmd_rd |=> rd_ack_r) // R5
    else $error("read not acknowledged");
  AST_BAD_WR: assert property (cmd_wr && !load_r && !nvm_restore
    && !valid_of(cmd_code, cmd_wdata) |=> stat_r.cml_data && notify_r && $stable(loop_r)
    && $stable(fsw_r) && $stable(floor_r) && $stable(input_turn_on_threshold_r))
    else $error("invalid write not refused"); // R7
  AST_FLOOR: assert property (1'b1 |=> target_r >= $past(floor_r))
    else $error("target below floor"); // R8
  AST_WARN: assert property ($rose(below) |=> notify_r && stat_r.none_above
    && stat_r.vout && stat_r.vout_minmax && target_r == $past(floor_r))
    else $error("floor warning response missing"); // R10
  AST_WARN_ONCE: assert property (below_r && !wr_bad |=> !notify_r) // R10
    else $error("floor warning notified twice");
  // set wins over clear, so only a clear may drop a status bit
  AST_STAT_HOLD: assert property (stat_clr == 4'h0 |=> (stat_r & $past(stat_r)) == $past(stat_r))
    else $error("status bit lost without clear"); // R10
  AST_FSW_MAP: assert property (rst_b && !conv_en ##1 !conv_en
    |-> fsw_eff_r == fsw_map($past(fsw_r)))
    else $error("effective frequency mismatch"); // R15
  AST_START: assert property (lin_fix(vin_sense) < lin_fix(input_turn_on_threshold_r) |=> !conv_start_r)
    else $error("conversion start below threshold"); // R17
endmodule : pvsf_regs
`default_nettype wire

/* File: logic/pvsf_pkg.sv */
`default_nettype none
package pvsf_pkg;
  // ==========================================
  // command codes
  localparam logic [7:0] CMD_LOOP_SCALE = 8'h29;
  localparam logic [7:0] CMD_VOUT_FLOOR = 8'h2b;
  localparam logic [7:0] CMD_FSW = 8'h33;
  localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD = 8'h35;
  // ==========================================
  // linear word fields
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MAN_HI = 10;
  localparam logic [4:0] LOOP_EXP_RST = 5'h19;
  localparam logic [4:0] FRAC_BIAS = 5'h10;
  localparam logic [10:0] FREQUENCY_MANTISSA_LIM = 11'h400;
  // ==========================================
  // decoded thresholds, 16 fraction bits
  localparam logic signed [47:0] Q_ZERO = 48'sh0;
  localparam logic signed [47:0] Q_EIGHTH = 48'sh2000;
  localparam logic signed [47:0] Q_QUARTER = 48'sh4000;
  localparam logic signed [47:0] Q_HALF = 48'sh8000;
  localparam logic signed [47:0] Q_ONE = 48'sh10000;
  localparam logic signed [47:0] INPUT_TURN_ON_THRESHOLD_LO = 48'sh28000;
  localparam logic signed [47:0] INPUT_TURN_ON_THRESHOLD_HI = 48'sh124000;
  // arbitrary plain bounds shared with the ceiling limit
  localparam logic [15:0] VOUT_LIM_LO = 16'h0000;
  localparam logic [15:0] VOUT_LIM_HI = 16'hb000;
  // ==========================================
  // divider codes
  localparam logic [1:0] DIV_EIGHTH = 2'h0;
  localparam logic [1:0] DIV_QUARTER = 2'h1;
  localparam logic [1:0] DIV_HALF = 2'h2;
  localparam logic [1:0] DIV_ONE = 2'h3;
  // ==========================================
  // frequency buckets in khz: exclusive upper bound, effective value
  localparam int FSW_N = 12;
  localparam logic [10:0] FSW_UB [FSW_N] = '{11'h0fa, 11'h12c, 11'h15e,
    11'h19a, 11'h1f4, 11'h258, 11'h2bc, 11'h334, 11'h3e8, 11'h4b0, 11'h578, 11'h672};
  localparam logic [10:0] FSW_EFF [FSW_N] = '{11'h0e1, 11'h113, 11'h145,
    11'h177, 11'h1c2, 11'h226, 11'h28a, 11'h2ee, 11'h384, 11'h44c, 11'h514, 11'h5dc};
  // ==========================================
  // carriers
  typedef struct packed {
    logic [15:0] input_turn_on_threshold;
    logic [15:0] fsw_khz;
    logic [15:0] vout_floor;
    logic [10:0] loop_man;
  } pvsf_nvm_t;
  typedef struct packed {
    logic none_above;
    logic vout;
    logic vout_minmax;
    logic cml_data;
  } pvsf_stat_t;
endpackage : pvsf_pkg
`default_nettype wire

/* File: bench/pvsf_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// word-access host on the command port
module pvsf_host (
  // clock
  input wire logic clk_sys,
  // command port
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data_r,
  input wire logic rd_ack_r
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // fast settings assume an external supply on the regulator rail
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk_sys);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
    cmd_wdata <= ~data;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ack);
    @(posedge clk_sys);
    cmd_rd <= 1'b1;
    cmd_code <= code;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    #1;
    ack = rd_ack_r;
    data = rd_data_r;
  endtask : rd
  // write and read of one word on back to back edges
  task automatic wrrd(input logic [7:0] code, input logic [15:0] wdata,
    output logic [15:0] data, output logic ack);
    @(posedge clk_sys);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= wdata;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b1;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    #1;
    ack = rd_ack_r;
    data = rd_data_r;
  endtask : wrrd
endmodule : pvsf_host
`default_nettype wire

/* File: bench/pvsf_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pvsf_regs_tb;
  logic clk_sys, rst_b, cmd_wr, cmd_rd, rd_ack_r, conv_en, nvm_restore, analog_input_supply_cycle;
  logic conv_start_r, notify_r, rack;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rd_data_r, target_req, vin_sense, loop_hw_r, target_r, rdat;
  logic [1:0] div_sel_r;
  logic [10:0] fsw_eff_r;
  pvsf_pkg::pvsf_nvm_t nvm;
  pvsf_pkg::pvsf_stat_t stat_clr, stat_r;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] lw [8] = '{16'hc810, 16'hc811, 16'hc820, 16'hc821, 16'hc840, 16'hc841,
    16'hc880, 16'hf801};
  logic [1:0] ld [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2};
  int fk [12] = '{249, 250, 300, 409, 410, 599, 600, 819, 999, 1000, 1398, 1648};
  int fe [12] = '{225, 275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500};
  logic [7:0] bc [6] = '{8'h29, 8'h29, 8'h33, 8'h35, 8'h2b, 8'h30};
  logic [15:0] bw [6] = '{16'hc800, 16'hc881, 16'h0b39, 16'hf009, 16'hb001, 16'h1234};
  logic [15:0] vs [3] = '{16'hf00b, 16'hf00c, 16'hf806};

  pvsf_regs pvsf_regs_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_r(rd_data_r),
    .rd_ack_r(rd_ack_r), .conv_en(conv_en), .nvm_restore(nvm_restore),
    .analog_input_supply_cycle(analog_input_supply_cycle), .nvm(nvm), .target_req(target_req), .vin_sense(vin_sense),
    .stat_clr(stat_clr), .div_sel_r(div_sel_r), .loop_hw_r(loop_hw_r),
    .fsw_eff_r(fsw_eff_r), .target_r(target_r), .conv_start_r(conv_start_r),
    .stat_r(stat_r), .notify_r(notify_r));
  pvsf_host pvsf_host_inst (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ==========================================
  // helpers
  function automatic logic [15:0] enc(input int k);
    return (k < 1024) ? {5'h00, k[10:0]} : {5'h01, k[11:1]};
  endfunction : enc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
    pvsf_host_inst.rd(code, rdat, rack);
    chk({15'h0, rack}, 16'h1, "ack");
    chk(rdat, exp, "read");
  endtask : rdchk
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic clr();
    @(posedge clk_sys);
    stat_clr <= 4'hf;
    @(posedge clk_sys);
    stat_clr <= 4'h0;
  endtask : clr
  task automatic pulse(input logic restore);
    @(posedge clk_sys);
    if (restore) nvm_restore <= 1'b1;
    else analog_input_supply_cycle <= 1'b1;
    @(posedge clk_sys);
    nvm_restore <= 1'b0;
    analog_input_supply_cycle <= 1'b0;
  endtask : pulse
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    #40000;
    miscompares++;
    conclude();
  end
  // ==========================================
  // tests
  initial begin
    rst_b = 1'b0;
    {conv_en, nvm_restore, analog_input_supply_cycle} = 3'h0;
    stat_clr = 4'h0;
    target_req = 16'h2000;
    vin_sense = 16'h0000;
    nvm = {16'hf00c, 16'd1200, 16'h1000, 11'h010};
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdchk(8'h29, 16'hc810);
    rdchk(8'h33, 16'h0a58);
    rdchk(8'h2b, 16'h1000);
    rdchk(8'h35, 16'hf00c);
    chk({14'h0, div_sel_r}, {14'h0, pvsf_pkg::DIV_EIGHTH}, "div");
    chk({5'h0, fsw_eff_r}, 16'd1300, "fsw");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pvsf_host_inst.wr(8'h29, lw[i]);
      settle();
      chk({14'h0, div_sel_r}, {14'h0, ld[i]}, "div");
      chk(loop_hw_r, lw[i], "loop hw");
      rdchk(8'h29, lw[i]);
    end
    for (int i = 0; i < 12; i++) begin
      pvsf_host_inst.wr(8'h33, enc(fk[i]));
      settle();
      chk({5'h0, fsw_eff_r}, 16'(fe[i]), "fsw");
    end
    pvsf_host_inst.wrrd(8'h35, 16'hf00e, rdat, rack);
    chk({15'h0, rack}, 16'h1, "ack");
    chk(rdat, 16'hf00e, "write then read");
    $display("test idle apply done");
    for (int i = 0; i < 6; i++) begin
      pvsf_host_inst.wr(bc[i], bw[i]);
      chk({15'h0, notify_r}, 16'h1, "notify");
      chk({15'h0, stat_r.cml_data}, 16'h1, "cml");
      clr();
    end
    rdchk(8'h29, 16'hf801);
    pvsf_host_inst.wr(8'h2b, 16'hb000);
    settle();
    rdchk(8'h2b, 16'hb000);
    chk(target_r, 16'hb000, "clamp");
    pvsf_host_inst.wr(8'h2b, 16'h1000);
    $display("test invalid done");
    @(posedge clk_sys);
    conv_en <= 1'b1;
    pvsf_host_inst.wr(8'h29, 16'hc880);
    pvsf_host_inst.wr(8'h33, enc(300));
    settle();
    chk({14'h0, div_sel_r}, 16'h2, "div held");
    chk({5'h0, fsw_eff_r}, 16'd1500, "fsw held");
    pulse(1'b0);
    settle();
    chk(loop_hw_r, 16'hc880, "analog_input_supply");
    chk({5'h0, fsw_eff_r}, 16'd325, "analog_input_supply fsw");
    nvm.fsw_khz <= 16'd600;
    pulse(1'b1);
    settle();
    chk({5'h0, fsw_eff_r}, 16'd650, "restore");
    chk(loop_hw_r, 16'hc810, "restore loop");
    rdchk(8'h33, 16'h0258);
    $display("test blocked done");
    @(posedge clk_sys);
    target_req <= 16'h0800;
    @(posedge clk_sys);
    #1;
    chk(target_r, 16'h1000, "floor");
    chk({13'h0, stat_r[3:1]}, 16'h7, "stat");
    chk({15'h0, notify_r}, 16'h1, "notify");
    @(posedge clk_sys);
    #1;
    chk({15'h0, notify_r}, 16'h0, "notify");
    target_req <= 16'h2000;
    clr();
    pvsf_host_inst.wr(8'h2b, 16'h3000);
    for (int i = 0; i < 4 && notify_r !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({15'h0, notify_r}, 16'h1, "notify");
    chk(target_r, 16'h3000, "floor");
    chk({13'h0, stat_r[3:1]}, 16'h7, "stat");
    $display("test floor done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      vin_sense <= vs[i];
      settle();
      chk({15'h0, conv_start_r}, (i == 0) ? 16'h0 : 16'h1, "start");
    end
    $display("test turn-on done");
    conclude();
  end
endmodule : pvsf_regs_tb
`default_nettype wire
